// File: hdl/bpc_cmd_reg.sv
// Primary interface command register and the gating it applies
//
// How it works
// - I/O claim only while I/O enable set
// - Memory claim only while memory enable set
// - Master enable gates initiating and secondary acceptance
// - Configuration forwarding ignores master enable
// - Special cycle bit reads zero, never responds
// - Write-and-invalidate bit reads zero, ignores writes
// - Palette write is I/O at three addresses
// - With I/O enable set, palette snoop forwards palette writes, else window
// - Parity response clear blocks parity error reporting
// - Parity response set allows error reporting
// - Wait cycle bit reads zero
// - System fault pin driven only when enabled
// - Fast back-to-back only when enabled
// - Bits 15:10 reserved, read zero
// - Reached only by primary Type 0 configuration
// - Only enabled bytes are written or returned
`timescale 1ns/1ps
module bpc_cmd_reg
  import bpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  // Primary Type 0 configuration data phase
  input wire logic cfgValid,
  input wire logic cfgWrite,
  input wire logic [5:0] cfgDword,
  input wire logic [3:0] cfgByteEnN,
  input wire logic [31:0] cfgWrData,
  output logic cfgHit,
  output logic [31:0] cfgRdData,
  // Primary target decode requests
  input wire logic priIoDecode,
  input wire logic priMemDecode,
  input wire logic priIoWrite,
  input wire logic [31:0] priAddr,
  input wire logic priInIoWindow,
  input wire logic priSpecialCycle,
  output logic priIoClaim,
  output logic priMemClaim,
  output logic paletteForward,
  output logic specialClaim,
  // Mastering and forwarding
  input wire logic secIoMemReq,
  input wire logic priInitReq,
  input wire logic cfgFwdReq,
  input wire logic b2bReq,
  output logic secAccept,
  output logic priInitiate,
  output logic cfgFwdGo,
  output logic b2bGo,
  // Error signalling
  input wire logic dataParityErr,
  input wire logic priIsMaster,
  input wire logic addrParityErr,
  input wire logic otherFaultCond,
  output logic perrAssert,
  output logic dataParityReportedSet,
  output logic systemFaultAssert,
  // Control levels for the rest of the bridge
  output logic [15:0] command
);
  logic [15:0] cmdReg;
  wire logic cmdSel;
  wire logic cmdWrite;
  wire logic [15:0] byteMask;
  wire logic [15:0] next_cmdReg;
  wire logic [31:0] next_cfgRdData;
  wire logic paletteHit;
  wire logic ioEn;
  wire logic memEn;
  wire logic masterEn;
  wire logic paletteEn;
  wire logic parityEn;
  wire logic faultEn;
  wire logic fastB2bEn;

  // Only configuration cycles decoded to this dword reach the register
  assign cmdSel = cfgValid && (cfgDword == BPC_CMD_DWORD);
  assign cmdWrite = cmdSel && cfgWrite;
  // Lanes 2 and 3 carry the status half, which lives outside this block
  for (genvar lane = 0; lane < 2; lane++) begin : gLane
    wire logic laneOn;
    assign laneOn = !cfgByteEnN[lane];
    assign byteMask[lane*8 +: 8] = {8{laneOn}};
  end

  // Read-only and reserved positions never take write data
  assign next_cmdReg = cmdWrite ?
    ((cmdReg & ~(byteMask & BPC_CMD_WR_MASK)) |
     (cfgWrData[15:0] & byteMask & BPC_CMD_WR_MASK)) : cmdReg;

  // Upper half belongs to the status register, not this block
  assign next_cfgRdData = (cmdSel && !cfgWrite) ?
    {16'h0000, cmdReg & byteMask & BPC_CMD_WR_MASK} : 32'h0000_0000;

  assign ioEn = cmdReg[BPC_BIT_IO];
  assign memEn = cmdReg[BPC_BIT_MEM];
  assign masterEn = cmdReg[BPC_BIT_MASTER];
  assign paletteEn = cmdReg[BPC_BIT_PALETTE];
  assign parityEn = cmdReg[BPC_BIT_PARITY];
  assign faultEn = cmdReg[BPC_BIT_SYSFAULT];
  assign fastB2bEn = cmdReg[BPC_BIT_FASTB2B];

  bpc_palette_decode uPal (
    .ioWrite(priIoWrite),
    .addr(priAddr),
    .hit(paletteHit)
  );

  // Gated decisions are registered so every output is a flop; one cycle of latency
  wire logic next_priIoClaim;
  wire logic next_priMemClaim;
  wire logic next_paletteForward;
  wire logic next_secAccept;
  wire logic next_priInitiate;
  wire logic next_cfgFwdGo;
  wire logic next_b2bGo;
  wire logic next_perrAssert;
  wire logic next_dprSet;
  wire logic next_faultAssert;

  // Palette writes outside the window are claimed only when snooping
  // Forwarding needs a claim, so the I/O enable gates snooped writes as well
  assign next_paletteForward = ioEn && paletteHit && (paletteEn || priInIoWindow);
  assign next_priIoClaim = ioEn && (priIoDecode || (paletteHit && paletteEn));
  assign next_priMemClaim = memEn && priMemDecode;
  assign next_secAccept = masterEn && secIoMemReq;
  assign next_priInitiate = masterEn && priInitReq;
  assign next_cfgFwdGo = cfgFwdReq;
  assign next_b2bGo = fastB2bEn && b2bReq;
  assign next_perrAssert = parityEn && dataParityErr;
  assign next_dprSet = parityEn && dataParityErr && priIsMaster;
  // Address parity needs both enables; other faults need only the pin enable
  assign next_faultAssert = faultEn && ((parityEn && addrParityErr) || otherFaultCond);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmdReg <= BPC_CMD_RESET;
    end else begin
      cmdReg <= next_cmdReg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgHit <= 1'b0;
      cfgRdData <= 32'h0000_0000;
    end else begin
      cfgHit <= cmdSel;
      cfgRdData <= next_cfgRdData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      priIoClaim <= 1'b0;
      priMemClaim <= 1'b0;
      paletteForward <= 1'b0;
    end else begin
      priIoClaim <= next_priIoClaim;
      priMemClaim <= next_priMemClaim;
      paletteForward <= next_paletteForward;
    end
  end

  // Kept as a flop so the port matches the others; it never rises
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      specialClaim <= 1'b0;
    end else begin
      specialClaim <= 1'b0 & priSpecialCycle;
    end
  end

  // Secondary-side requests and primary mastering share one enable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secAccept <= 1'b0;
      priInitiate <= 1'b0;
    end else begin
      secAccept <= next_secAccept;
      priInitiate <= next_priInitiate;
    end
  end

  // Configuration forwarding has no enable to wait for
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgFwdGo <= 1'b0;
      b2bGo <= 1'b0;
    end else begin
      cfgFwdGo <= next_cfgFwdGo;
      b2bGo <= next_b2bGo;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      perrAssert <= 1'b0;
      dataParityReportedSet <= 1'b0;
      systemFaultAssert <= 1'b0;
    end else begin
      perrAssert <= next_perrAssert;
      dataParityReportedSet <= next_dprSet;
      systemFaultAssert <= next_faultAssert;
    end
  end

  // Loaded from the next value so the levels never lag the readback
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      command <= BPC_CMD_RESET;
    end else begin
      command <= next_cmdReg;
    end
  end
endmodule : bpc_cmd_reg

// File: hdl/bpc_palette_decode.sv
// Palette write address decoder
`timescale 1ns/1ps
module bpc_palette_decode
  import bpc_pkg::*;
(
  input wire logic ioWrite,
  input wire logic [31:0] addr,
  output logic hit
);
  // Bits 15:10 are deliberately not looked at
  wire logic lowMatch;
  wire logic upperZero;
  assign lowMatch = (addr[9:0] == BPC_PAL_ADDR_A) || (addr[9:0] == BPC_PAL_ADDR_B) ||
                    (addr[9:0] == BPC_PAL_ADDR_C);
  assign upperZero = (addr[31:16] == BPC_PAL_UPPER);
  assign hit = ioWrite && lowMatch && upperZero;
endmodule : bpc_palette_decode

// File: hdl/bpc_pkg.sv
// Constants for the primary interface command register block
package bpc_pkg;
  localparam logic [5:0] BPC_CMD_DWORD = 6'h01;
  localparam logic [7:0] BPC_CMD_OFFSET = 8'h04;
  localparam logic [15:0] BPC_CMD_RESET = 16'h0000;
  localparam logic [15:0] BPC_CMD_WR_MASK = 16'h0367;
  localparam int BPC_BIT_IO = 0;
  localparam int BPC_BIT_MEM = 1;
  localparam int BPC_BIT_MASTER = 2;
  localparam int BPC_BIT_SPECIAL = 3;
  localparam int BPC_BIT_MWI = 4;
  localparam int BPC_BIT_PALETTE = 5;
  localparam int BPC_BIT_PARITY = 6;
  localparam int BPC_BIT_WAIT = 7;
  localparam int BPC_BIT_SYSFAULT = 8;
  localparam int BPC_BIT_FASTB2B = 9;
  localparam logic [9:0] BPC_PAL_ADDR_A = 10'h3c6;
  localparam logic [9:0] BPC_PAL_ADDR_B = 10'h3c8;
  localparam logic [9:0] BPC_PAL_ADDR_C = 10'h3c9;
  localparam logic [15:0] BPC_PAL_UPPER = 16'h0000;
endpackage : bpc_pkg

// File: verif/bpc_checker.sv
// Port-level assertions for the command register
`timescale 1ns/1ps
module bpc_checker
  import bpc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cfgValid,
  input wire logic [5:0] cfgDword,
  input wire logic cfgHit,
  input wire logic priMemDecode,
  input wire logic priMemClaim,
  input wire logic secIoMemReq,
  input wire logic secAccept,
  input wire logic cfgFwdReq,
  input wire logic cfgFwdGo,
  input wire logic b2bReq,
  input wire logic b2bGo,
  input wire logic dataParityErr,
  input wire logic perrAssert,
  input wire logic systemFaultAssert,
  input wire logic [15:0] command
);
  // Skips the first edge, whose flops were still held in reset
  logic up;
  always_ff @(posedge clk) up <= rst_n;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ro_bits_a: assert property ((command & ~BPC_CMD_WR_MASK) == 16'h0000)
    else $error("read-only bit set");
  mem_gate_a: assert property (up |-> priMemClaim == $past(command[1] && priMemDecode))
    else $error("memory claim wrong");
  master_gate_a: assert property (up |-> secAccept == $past(command[2] && secIoMemReq))
    else $error("secondary accept wrong");
  cfg_fwd_a: assert property (up |-> cfgFwdGo == $past(cfgFwdReq))
    else $error("config forward gated");
  parity_gate_a: assert property (up |-> perrAssert == $past(command[6] && dataParityErr))
    else $error("parity pin wrong");
  fault_gate_a: assert property (systemFaultAssert |-> $past(command[8]))
    else $error("fault pin while disabled");
  b2b_gate_a: assert property (up |-> b2bGo == $past(command[9] && b2bReq))
    else $error("back-to-back wrong");
  cfg_hit_a: assert property (up |-> cfgHit == $past(cfgValid && cfgDword == BPC_CMD_DWORD))
    else $error("config hit wrong");
  cover property (cfgHit);
  cover property (priMemClaim);
  cover property (systemFaultAssert);
endmodule : bpc_checker
bind bpc_cmd_reg bpc_checker chk (.*);

// File: verif/bpc_host_model.sv
// Host configuration software issuing Type 0 data phases
`timescale 1ns/1ps
module bpc_host_model (
  input wire logic clk,
  output logic cfgValid = 1'b0,
  output logic cfgWrite = 1'b0,
  output logic [5:0] cfgDword = 6'h00,
  output logic [3:0] cfgByteEnN = 4'hf,
  output logic [31:0] cfgWrData = 32'h0
);
  task automatic access(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] d);
    @(negedge clk);
    cfgValid = 1'b1;
    cfgWrite = wr;
    cfgDword = dw;
    cfgByteEnN = be;
    cfgWrData = d;
    @(negedge clk);
    cfgValid = 1'b0;
    // Released bus shows no stale data
    cfgWrData = ~d;
  endtask : access
endmodule : bpc_host_model

// File: verif/testbench.sv
// Self-checking bench with a reference model of the command register
`timescale 1ns/1ps
module testbench
  import bpc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cfgValid, cfgWrite, cfgHit;
  logic [5:0] cfgDword;
  logic [3:0] cfgByteEnN;
  logic [31:0] cfgWrData, cfgRdData, priAddr;
  logic [15:0] command;
  logic [12:0] stim;
  logic [10:0] outs;
  logic [31:0] addrs [4] = '{32'h3c6, 32'h3c8, 32'h103c9, 32'h3c9};
  int mismatches = 0;
  int checked = 0;
  int cmd = 0;
  always #10 clk = ~clk;
  bpc_host_model host (.*);
  bpc_cmd_reg dut (.*, .priIoDecode(stim[0]), .priMemDecode(stim[1]), .priIoWrite(stim[2]),
    .priInIoWindow(stim[3]), .priSpecialCycle(stim[4]), .secIoMemReq(stim[5]),
    .priInitReq(stim[6]), .cfgFwdReq(stim[7]), .b2bReq(stim[8]), .dataParityErr(stim[9]),
    .priIsMaster(stim[10]), .addrParityErr(stim[11]), .otherFaultCond(stim[12]),
    .priIoClaim(outs[0]), .priMemClaim(outs[1]), .paletteForward(outs[2]),
    .specialClaim(outs[3]), .secAccept(outs[4]), .priInitiate(outs[5]), .cfgFwdGo(outs[6]),
    .b2bGo(outs[7]), .perrAssert(outs[8]), .dataParityReportedSet(outs[9]),
    .systemFaultAssert(outs[10]));
  function automatic logic [10:0] gate(input logic [12:0] s, input logic [31:0] a, input int c);
    logic p;
    p = s[2] && a[31:16] == 0 && (a[9:0] == 10'h3c6 || a[9:0] == 10'h3c8 || a[9:0] == 10'h3c9);
    return {c[8] & (c[6] & s[11] | s[12]), c[6] & s[9] & s[10], c[6] & s[9], c[9] & s[8],
      s[7], c[2] & s[6], c[2] & s[5], 1'b0, c[0] & p & (c[5] | s[3]), c[1] & s[1],
      c[0] & (s[0] | p & c[5])};
  endfunction : gate
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    mismatches++;
    conclude();
  end
  initial begin
    logic [3:0] be;
    logic [5:0] dw;
    logic [31:0] d;
    logic wr;
    stim = '0;
    priAddr = '0;
    void'($urandom(32'h8180));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("reset", command, 16'h0000);
    for (int i = 0; i < 200; i++) begin
      wr = (i == 0) || ($urandom % 2 == 1);
      dw = ($urandom % 4 == 0) ? 6'($urandom) : BPC_CMD_DWORD;
      be = (i == 0) ? 4'h0 : 4'($urandom);
      d = (i == 0) ? 32'hffffffff : $urandom;
      host.access(wr, dw, be, d);
      chk("hit", cfgHit, dw == BPC_CMD_DWORD);
      chk("rdata", cfgRdData, (!wr && dw == 1) ? 16'(cmd) & {{8{!be[1]}}, {8{!be[0]}}} : 0);
      if (wr && dw == 1 && !be[0]) cmd[7:0] = d[7:0] & 8'h67;
      if (wr && dw == 1 && !be[1]) cmd[15:8] = d[15:8] & 8'h03;
      chk("command", command, cmd);
      stim = 13'($urandom);
      priAddr = addrs[$urandom % 4] | ($urandom & 32'h0000fc00);
      @(negedge clk);
      chk("gates", outs, gate(stim, priAddr, cmd));
    end
    // Mid-run reset must clear whatever the loop left behind
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    cmd = 0;
    chk("midreset", command, cmd);
    rst_n = 1'b1;
    host.access(1'b1, BPC_CMD_DWORD, 4'h0, 32'hffff_ffff);
    chk("command", command, BPC_CMD_WR_MASK);
    host.access(1'b0, BPC_CMD_DWORD, 4'h0, 32'h0000_0000);
    chk("readback", cfgRdData, BPC_CMD_WR_MASK);
    conclude();
  end
endmodule : testbench
